// ===== src/spc_map.vh
// Functional notes
// - Match interrupt enable with match flag set raises the interrupt; clear means polling.
// - Bit 6 of control register two is not implemented and reads zero.
// - In slave mode mode-fault enable is ignored; select pin is slave select input.
// - Master with mode-fault enable clear releases select pin to general-purpose use.
// - Master with mode-fault enable set uses select pin as fault input or output.
// - Select output enable one drives select automatically; zero makes it fault input.
// - With pin control zero, the bidirectional output enable affects no pin.
// - In bidirectional mode output enable gates the driver onto the single data pin.
// - Wait-stop bit one stops port clocks in wait mode; zero keeps them running.
// - Pin control zero: master in on MISO, out on MOSI; slave the reverse.
// - Pin control one in master: MISO unused, MOSI input or I/O by output enable.
// - Pin control one in slave: MOSI unused, MISO input or I/O by output enable.
`ifndef SPC_MAP_VH
`define SPC_MAP_VH

// =====================================================================
// Register indices; the byte address is four times the index.
// =====================================================================
`define SPC_IDX_CONTROL_ONE 3'h0
`define SPC_IDX_CONTROL_TWO 3'h1
`define SPC_IDX_DATA        3'h2
`define SPC_IDX_MATCH       3'h3
`define SPC_IDX_IRQ_STATUS  3'h4
`define SPC_IDX_IRQ_MASK    3'h5

// =====================================================================
// Field positions.
// =====================================================================
`define SPC_C1_PORT_ENABLE   0
`define SPC_C1_MASTER_SELECT 1
`define SPC_C1_SELECT_OE     2
`define SPC_C2_MATCH_IRQ_EN  7
`define SPC_C2_UNIMPL        6
`define SPC_C2_MODE_FAULT_EN 4
`define SPC_C2_BIDIR_OE      3
`define SPC_C2_WAIT_STOP     1
`define SPC_C2_PIN_CTRL      0
`define SPC_C2_WRITE_MASK    8'h9B
`define SPC_IRQ_MATCH        0
`define SPC_IRQ_MODE_FAULT   1
`define SPC_IRQ_DONE         2

// =====================================================================
// Reset values and timing counts.
// =====================================================================
`define SPC_C1_RESET       8'h00
`define SPC_C2_RESET       8'h00
`define SPC_MATCH_RESET    8'h00
`define SPC_MASK_RESET     3'h0
`define SPC_SCK_HALF_COUNT 4
`define SPC_BITS_PER_FRAME 4'h8

`endif

// ===== src/spc_sync.v
`timescale 1ns/100ps
`include "spc_map.vh"

// =====================================================================
// Two-stage synchroniser for pin inputs from outside the clock domain.
// =====================================================================
module spc_sync #(
    parameter WIDTH = 4
) (
    input  wire             mclk_in,
    input  wire             rst_n_in,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] stage1_reg;
    reg [WIDTH-1:0] stage2_reg;

    // The first stage feeds only the second stage, so metastability settles there.
    always @(posedge mclk_in) begin
        if (!rst_n_in) begin
            stage1_reg <= {WIDTH{1'b0}};
            stage2_reg <= {WIDTH{1'b0}};
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_out = stage2_reg;

endmodule

// ===== src/spc_pin_ctrl.v
`timescale 1ns/100ps
`include "spc_map.vh"

// =====================================================================
// Serial port with pin-option control, Avalon-MM register slave.
// =====================================================================
module spc_pin_ctrl #(
    parameter SCK_HALF = `SPC_SCK_HALF_COUNT
) (
    input  wire       mclk_in,
    input  wire       rst_n_in,
    input  wire [4:0] avs_address_in,
    input  wire       avs_read_in,
    input  wire       avs_write_in,
    input  wire [7:0] avs_writedata_in,
    output wire [7:0] avs_readdata_out,
    output wire       avs_waitrequest_out,
    input  wire       wait_mode_in,
    output wire       irq_out,
    output wire       port_clock_run_out,
    output wire       select_owned_out,
    input  wire       sck_in,
    output wire       sck_out,
    output wire       sck_oe_out,
    input  wire       mosi_in,
    output wire       mosi_out,
    output wire       mosi_oe_out,
    input  wire       miso_in,
    output wire       miso_out,
    output wire       miso_oe_out,
    input  wire       ss_n_in,
    output wire       ss_n_out,
    output wire       ss_n_oe_out
);

    // =================================================================
    // Register state.
    // =================================================================
    reg [7:0] control_one_reg;
    reg [7:0] spi_control_two_reg;
    reg [7:0] match_value_reg;
    reg [7:0] rx_data_reg;
    reg [2:0] irq_status_reg;
    reg [2:0] irq_mask_reg;
    reg [7:0] readdata_reg;
    reg       ack_reg;

    // Shifter state.
    reg [7:0] shift_reg;
    reg       rx_bit_reg;
    reg [3:0] bit_cnt_reg;
    reg       busy_reg;
    reg       sck_drive_reg;
    reg [7:0] div_cnt_reg;
    reg       sck_prev_reg;

    wire [3:0] pin_sync;
    wire       sck_s;
    wire       mosi_s;
    wire       miso_s;
    wire       ss_n_s;

    // =================================================================
    // Pin synchronisers.
    // =================================================================
    spc_sync #(
        .WIDTH (4)
    ) u_sync (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .async_in ({ss_n_in, miso_in, mosi_in, sck_in}),
        .sync_out (pin_sync)
    );

    // Synchronised pins, unpacked in the order they were packed above.
    assign sck_s  = pin_sync[0];
    assign mosi_s = pin_sync[1];
    assign miso_s = pin_sync[2];
    assign ss_n_s = pin_sync[3];

    // =================================================================
    // Field decode.
    // =================================================================
    // Control bits by name; positions that never store have no decode here.
    wire port_en     = control_one_reg[`SPC_C1_PORT_ENABLE];
    wire master_select = control_one_reg[`SPC_C1_MASTER_SELECT];
    wire select_output_enable = control_one_reg[`SPC_C1_SELECT_OE];
    wire match_irq_enable     = spi_control_two_reg[`SPC_C2_MATCH_IRQ_EN];
    wire mode_fault_enable    = spi_control_two_reg[`SPC_C2_MODE_FAULT_EN];
    wire bidir_output_enable  = spi_control_two_reg[`SPC_C2_BIDIR_OE];
    wire wait_clock_stop      = spi_control_two_reg[`SPC_C2_WAIT_STOP];
    wire pin_control_bidir    = spi_control_two_reg[`SPC_C2_PIN_CTRL];

    // Port clocks halt in wait mode only when the wait-stop bit asks for it.
    wire port_run = port_en & ~(wait_clock_stop & wait_mode_in);
    assign port_clock_run_out = port_run;

    // In master mode the select pin is the port's own only with fault enable set.
    wire ss_spi_owned = master_select & mode_fault_enable;
    wire ss_auto_out  = ss_spi_owned & select_output_enable;
    wire fault_input  = ss_spi_owned & ~select_output_enable;
    // Slave mode ignores fault enable: select is always the slave select input.
    wire slave_selected = ~master_select & ~ss_n_s;
    assign select_owned_out = port_en & (~master_select | ss_spi_owned);

    // =================================================================
    // Avalon-MM access: one wait cycle, then the access completes.
    // =================================================================
    wire       req      = avs_read_in | avs_write_in;
    wire       do_write = avs_write_in & ack_reg;
    wire [2:0] idx      = avs_address_in[4:2];
    wire       addr_low_ok = (avs_address_in[1:0] == 2'b00);

    // Waitrequest is combinational, so the first cycle of every request stalls.
    assign avs_waitrequest_out = req & ~ack_reg;
    assign avs_readdata_out    = readdata_reg;

    function sel;
        input [2:0] i;
        input [2:0] target;
        begin
            sel = addr_low_ok && (i == target);
        end
    endfunction

    // Read mux; reserved and unimplemented positions read zero.
    reg [7:0] rd_mux;
    always @* begin
        rd_mux = 8'h00;
        if (sel(idx, `SPC_IDX_CONTROL_ONE)) begin
            rd_mux = {5'h00, control_one_reg[2:0]};
        end else if (sel(idx, `SPC_IDX_CONTROL_TWO)) begin
            rd_mux = spi_control_two_reg & `SPC_C2_WRITE_MASK;
        end else if (sel(idx, `SPC_IDX_DATA)) begin
            rd_mux = rx_data_reg;
        end else if (sel(idx, `SPC_IDX_MATCH)) begin
            rd_mux = match_value_reg;
        end else if (sel(idx, `SPC_IDX_IRQ_STATUS)) begin
            rd_mux = {5'h00, irq_status_reg};
        end else if (sel(idx, `SPC_IDX_IRQ_MASK)) begin
            rd_mux = {5'h00, irq_mask_reg[2:1], match_irq_enable};
        end
    end

    // Acknowledge toggles so each request sees exactly one wait cycle.
    always @(posedge mclk_in) begin
        if (!rst_n_in) begin
            ack_reg      <= 1'b0;
            readdata_reg <= 8'h00;
        end else begin
            ack_reg <= req & ~ack_reg;
            if (avs_read_in && !ack_reg) begin
                readdata_reg <= rd_mux;
            end
        end
    end

    // =================================================================
    // Shifter events.
    // =================================================================
    // Last bit index of a frame; the bit counter restarts after it.
    localparam [3:0] LAST_BIT = `SPC_BITS_PER_FRAME - 4'h1;

    // Link clock edges as seen through the synchroniser, two cycles late.
    wire sck_rise = sck_s & ~sck_prev_reg;
    wire sck_fall = ~sck_s & sck_prev_reg;
    // One-cycle enable pulse every half period of the link clock, SCK_HALF master clocks.
    wire div_tick = (div_cnt_reg == SCK_HALF[7:0] - 8'h01);
    wire data_wr  = do_write & sel(idx, `SPC_IDX_DATA);
    wire start    = data_wr & master_select & port_run & ~busy_reg;

    // Data input pin: normal mode uses the opposite pin, bidir uses the shared one.
    reg din;
    always @* begin
        if (master_select) begin
            din = pin_control_bidir ? mosi_s : miso_s;
        end else begin
            din = pin_control_bidir ? miso_s : mosi_s;
        end
    end

    wire m_sample = busy_reg & master_select & port_run & div_tick & ~sck_drive_reg;
    wire m_shift  = busy_reg & master_select & port_run & div_tick & sck_drive_reg;
    wire s_sample = slave_selected & port_run & sck_rise;
    wire s_shift  = slave_selected & port_run & sck_fall;
    wire sample   = m_sample | s_sample;
    wire frame_done = sample & (bit_cnt_reg == LAST_BIT);
    // A master frame ends on the falling edge that follows its last sample.
    wire m_last     = m_shift & (bit_cnt_reg == 4'h0);
    wire [7:0] rx_byte = {shift_reg[6:0], din};
    wire match_event = frame_done & (rx_byte == match_value_reg);
    // Mode fault: another master pulled select low while we own it as input.
    wire fault_event = port_en & fault_input & ~ss_n_s;

    // Edge history for the sampled link clock.
    always @(posedge mclk_in) begin
        if (!rst_n_in) begin
            sck_prev_reg <= 1'b0;
        end else begin
            sck_prev_reg <= sck_s;
        end
    end

    // Master clock divider; a stopped port holds the count rather than drifting.
    always @(posedge mclk_in) begin
        if (!rst_n_in) begin
            div_cnt_reg <= 8'h00;
        end else if (!busy_reg || start) begin
            div_cnt_reg <= 8'h00;
        end else if (port_run) begin
            div_cnt_reg <= div_tick ? 8'h00 : div_cnt_reg + 8'h01;
        end
    end

    // Shift register, bit counter and master clock state.
    always @(posedge mclk_in) begin
        if (!rst_n_in) begin
            shift_reg     <= 8'h00;
            rx_bit_reg    <= 1'b0;
            bit_cnt_reg   <= 4'h0;
            busy_reg      <= 1'b0;
            sck_drive_reg <= 1'b0;
            rx_data_reg   <= 8'h00;
        end else if (!port_en || fault_event) begin
            busy_reg      <= 1'b0;
            sck_drive_reg <= 1'b0;
            bit_cnt_reg   <= 4'h0;
        end else begin
            if (start || (data_wr && !master_select && !slave_selected)) begin
                shift_reg   <= avs_writedata_in;
                bit_cnt_reg <= 4'h0;
                busy_reg    <= master_select;
            end
            if (!master_select && ss_n_s) begin
                bit_cnt_reg <= 4'h0;
            end
            if (sample) begin
                rx_bit_reg  <= din;
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            if (frame_done) begin
                rx_data_reg <= rx_byte;
                bit_cnt_reg <= 4'h0;
            end
            if (m_sample) begin
                sck_drive_reg <= 1'b1;
            end
            // The last falling edge of a master frame ends the transfer.
            if (m_shift) begin
                sck_drive_reg <= 1'b0;
                if (bit_cnt_reg == 4'h0) begin
                    busy_reg  <= 1'b0;
                    shift_reg <= rx_data_reg;
                end else begin
                    shift_reg <= {shift_reg[6:0], rx_bit_reg};
                end
            end
            if (s_shift) begin
                shift_reg <= {shift_reg[6:0], rx_bit_reg};
            end
        end
    end

    // =================================================================
    // Control registers. Reserved bits 5 and 2 and bit 6 of control two never store.
    // =================================================================
    always @(posedge mclk_in) begin
        if (!rst_n_in) begin
            control_one_reg     <= `SPC_C1_RESET;
            spi_control_two_reg <= `SPC_C2_RESET;
            match_value_reg     <= `SPC_MATCH_RESET;
            irq_mask_reg        <= `SPC_MASK_RESET;
        end else begin
            if (do_write && sel(idx, `SPC_IDX_CONTROL_ONE)) begin
                control_one_reg <= avs_writedata_in & 8'h07;
            end else if (fault_event) begin
                // A fault drops the port back to slave to avoid bus contention.
                control_one_reg[`SPC_C1_MASTER_SELECT] <= 1'b0;
            end
            if (do_write && sel(idx, `SPC_IDX_CONTROL_TWO)) begin
                // Writes to bits 5 and 2 are expected not to happen; they are discarded.
                spi_control_two_reg <= avs_writedata_in & `SPC_C2_WRITE_MASK;
            end else if (do_write && sel(idx, `SPC_IDX_IRQ_MASK)) begin
                spi_control_two_reg[`SPC_C2_MATCH_IRQ_EN] <= avs_writedata_in[`SPC_IRQ_MATCH];
            end
            if (do_write && sel(idx, `SPC_IDX_MATCH)) begin
                match_value_reg <= avs_writedata_in;
            end
            // Mask bit 0 is stored but unused; readback and the line both use control two's enable.
            if (do_write && sel(idx, `SPC_IDX_IRQ_MASK)) begin
                irq_mask_reg <= avs_writedata_in[2:0];
            end
        end
    end

    // =================================================================
    // Sticky status, write one to clear; a new event wins over the clear.
    // =================================================================
    // A slave frame is done at its eighth sample, a master one at its last falling edge.
    wire       done_event = m_last | (frame_done & ~master_select);
    wire [2:0] events     = {done_event, fault_event, match_event};
    // Only a write to the status word carries ones to clear.
    wire [2:0] w1c        = (do_write && sel(idx, `SPC_IDX_IRQ_STATUS)) ? avs_writedata_in[2:0] : 3'h0;

    // The set term is applied after the clear, so an event in the clear cycle survives.
    always @(posedge mclk_in) begin
        if (!rst_n_in) begin
            irq_status_reg <= 3'h0;
        end else begin
            irq_status_reg <= (irq_status_reg & ~w1c) | events;
        end
    end

    // Match flag reaches the line only through its own enable bit.
    assign irq_out = (match_irq_enable & irq_status_reg[`SPC_IRQ_MATCH]) |
                     |(irq_mask_reg[2:1] & irq_status_reg[2:1]);

    // =================================================================
    // Pin drivers.
    // =================================================================
    // The shifter's top bit is the outgoing data bit in either role.
    wire tx_bit = shift_reg[7];

    // Master drives the clock; a slave leaves it as an input.
    assign sck_out    = sck_drive_reg;
    assign sck_oe_out = port_en & master_select;

    // Master MOSI: always output in normal mode, gated by output enable in bidir.
    assign mosi_out    = tx_bit;
    assign mosi_oe_out = port_en & master_select &
                         (pin_control_bidir ? bidir_output_enable : 1'b1);

    // Slave MISO: drives while selected; in bidir, only when output enable is set.
    assign miso_out    = tx_bit;
    assign miso_oe_out = port_en & slave_selected &
                         (pin_control_bidir ? bidir_output_enable : 1'b1);

    // Automatic select goes low for the whole master frame.
    assign ss_n_out    = ~busy_reg;
    assign ss_n_oe_out = port_en & ss_auto_out;

endmodule

// ===== tb/spc_pin_ctrl_properties.sv
`timescale 1ns/100ps
// =====================================================================
// Port checker: keeps a shadow of control register two from bus writes.
// =====================================================================
module spc_pin_ctrl_checker (
    input wire       mclk_in,
    input wire       rst_n_in,
    input wire [4:0] avs_address_in,
    input wire       avs_read_in,
    input wire       avs_write_in,
    input wire [7:0] avs_writedata_in,
    input wire [7:0] avs_readdata_out,
    input wire       avs_waitrequest_out,
    input wire       wait_mode_in,
    input wire       irq_out,
    input wire       port_clock_run_out,
    input wire       sck_oe_out,
    input wire       mosi_oe_out,
    input wire       miso_oe_out,
    input wire       ss_n_oe_out
);
    reg [7:0] c2_reg;
    reg [1:0] msk_reg;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    // The mask's low bit reads and acts as the match enable, so both addresses update it.
    always @(posedge mclk_in) begin
        if (!rst_n_in) begin
            c2_reg <= 8'h00;
            msk_reg <= 2'h0;
        end else if (avs_write_in && !avs_waitrequest_out) begin
            if (avs_address_in == 5'h04) c2_reg <= avs_writedata_in & 8'h9B;
            if (avs_address_in == 5'h14) c2_reg[7] <= avs_writedata_in[0];
            if (avs_address_in == 5'h14) msk_reg <= avs_writedata_in[2:1];
        end
    end
    sequence s_req_wait;
        (avs_read_in || avs_write_in) && avs_waitrequest_out;
    endsequence
    sequence s_c2_read;
        avs_read_in && !avs_waitrequest_out && avs_address_in == 5'h04;
    endsequence
    a_one_wait: assert property (s_req_wait |=> !avs_waitrequest_out) else $error("wait too long");
    a_idle_nowait: assert property (!avs_read_in && !avs_write_in |-> !avs_waitrequest_out)
        else $error("idle wait");
    a_c2_readback: assert property (s_c2_read |-> avs_readdata_out == c2_reg) else $error("readback");
    a_bit6_zero: assert property (s_c2_read |-> !avs_readdata_out[6]) else $error("bit six set");
    a_irq_quiet: assert property (!c2_reg[7] && msk_reg == 2'h0 |-> !irq_out) else $error("irq raised");
    a_mosi_gate: assert property (mosi_oe_out && c2_reg[0] |-> c2_reg[3]) else $error("mosi driven");
    a_miso_gate: assert property (miso_oe_out && c2_reg[0] |-> c2_reg[3]) else $error("miso driven");
    a_wait_stop: assert property (wait_mode_in && c2_reg[1] |-> !port_clock_run_out)
        else $error("clock runs");
    a_ss_release: assert property (!c2_reg[4] |-> !ss_n_oe_out) else $error("select driven");
    a_master_pins: assert property (mosi_oe_out |-> sck_oe_out && !miso_oe_out) else $error("pin roles");
endmodule

// ===== tb/spc_far_dev.sv
`timescale 1ns/100ps
// =====================================================================
// Far-side serial slave, clock mode 0, most significant bit first.
// =====================================================================
module spc_far_dev (
    input  wire       sck_in,
    input  wire       ss_n_in,
    input  wire       mosi_in,
    input  wire [7:0] tx_in,
    output reg        miso_out,
    output reg  [7:0] rx_out
);
    reg [7:0] sh_reg;
    // Released, the line shows the inverse of its last bit, so stale data cannot pass.
    always @(ss_n_in) begin
        sh_reg = tx_in;
        miso_out = ss_n_in ? ~miso_out : tx_in[7];
    end
    // Sample on the rising clock edge, shift on the falling one.
    always @(posedge sck_in) begin
        if (!ss_n_in) rx_out = {rx_out[6:0], mosi_in};
    end
    always @(negedge sck_in) begin
        if (!ss_n_in) sh_reg = {sh_reg[6:0], 1'b0};
        if (!ss_n_in) miso_out = sh_reg[7];
    end
endmodule

// ===== tb/spc_pin_ctrl_tb.sv
`timescale 1ns/100ps
// =====================================================================
// Self-checking bench: register access, one frame, pin-role table.
// =====================================================================
module spc_pin_ctrl_tb;
    reg         mclk_in = 1'b0, rst_n_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0;
    reg  [4:0]  avs_address_in = 5'h00;
    reg  [7:0]  avs_writedata_in = 8'h00, far_tx = 8'h00, v;
    reg         wait_mode_in = 1'b0, ss_drv = 1'b1, tog = 1'b0;
    reg  [31:0] seed = 32'hD88F;
    reg  [22:0] rows [0:10];
    integer     num_errors = 0, n_checks = 0, i, t;
    logic [7:0] exp_q [$];
    wire [7:0]  avs_readdata_out, far_rx;
    wire        avs_waitrequest_out, irq_out, port_clock_run_out, select_owned_out, far_miso;
    wire        sck_out, sck_oe_out, mosi_out, mosi_oe_out, miso_out, miso_oe_out, ss_n_out, ss_n_oe_out;
    // The driving party wins; the far select is pulled up, the port's select follows ss_drv, and an undriven data line toggles.
    wire        sck_w = sck_oe_out ? sck_out : 1'b0;
    wire        ss_w = ss_n_oe_out ? ss_n_out : ss_drv;
    wire        far_ss = ss_n_oe_out ? ss_n_out : 1'b1;
    wire        mosi_w = mosi_oe_out ? mosi_out : tog;
    wire        miso_w = miso_oe_out ? miso_out : far_miso;
    wire [4:0]  roles = {mosi_oe_out, miso_oe_out, ss_n_oe_out, select_owned_out, port_clock_run_out};
    always #50 mclk_in = ~mclk_in;
    always @(posedge mclk_in) tog <= ~tog;
    spc_pin_ctrl dut_u (.mclk_in, .rst_n_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
        .avs_readdata_out, .avs_waitrequest_out, .wait_mode_in, .irq_out, .port_clock_run_out, .select_owned_out,
        .sck_in(sck_w), .sck_out, .sck_oe_out, .mosi_in(mosi_w), .mosi_out, .mosi_oe_out, .miso_in(miso_w),
        .miso_out, .miso_oe_out, .ss_n_in(ss_w), .ss_n_out, .ss_n_oe_out);
    spc_far_dev far_u (.sck_in(sck_w), .ss_n_in(far_ss), .mosi_in(mosi_w), .tx_in(far_tx), .miso_out(far_miso),
        .rx_out(far_rx));
    function automatic [31:0] xs(input [31:0] s);
        xs = s ^ (s << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    endfunction
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks = n_checks + 1;
        if (g !== e) begin
            num_errors = num_errors + 1;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // One bus transfer; the request stands until waitrequest is seen low, with no assumed latency.
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        integer n;
        n = 0;
        @(posedge mclk_in);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_write_in <= wr;
        avs_read_in <= ~wr;
        @(posedge mclk_in);
        while (avs_waitrequest_out !== 1'b0 && n < 50) begin
            n = n + 1;
            @(posedge mclk_in);
        end
        if (n == 50) num_errors = num_errors + 1;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 8'h00);
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Read data is taken at the edge where waitrequest is low and matched to the oldest note.
    always @(posedge mclk_in) begin
        if (avs_read_in && avs_waitrequest_out === 1'b0) begin
            if (exp_q.size() > 0) chk(avs_readdata_out, exp_q.pop_front());
            else num_errors = num_errors + 1;
        end
    end
    // A frame takes under a hundred cycles; twenty thousand means a hang.
    initial begin
        #2000000;
        num_errors = num_errors + 1;
        end_of_test;
    end
    // Rows: control one, control two, select level, wait mode, then the expected mosi, miso and
    // select enables, select ownership and clock run.
    initial begin
        rows[0] = {8'h03, 8'h00, 2'b10, 5'b10001};
        rows[1] = {8'h03, 8'h08, 2'b10, 5'b10001};
        rows[2] = {8'h03, 8'h01, 2'b10, 5'b00001};
        rows[3] = {8'h03, 8'h09, 2'b10, 5'b10001};
        rows[4] = {8'h07, 8'h10, 2'b10, 5'b10111};
        rows[5] = {8'h03, 8'h10, 2'b10, 5'b10011};
        rows[6] = {8'h01, 8'h00, 2'b00, 5'b01011};
        rows[7] = {8'h01, 8'h01, 2'b00, 5'b00011};
        rows[8] = {8'h01, 8'h09, 2'b00, 5'b01011};
        rows[9] = {8'h01, 8'h10, 2'b01, 5'b01011};
        rows[10] = {8'h01, 8'h12, 2'b01, 5'b01010};
        repeat (8) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        rd(5'h04, 8'h00);
        rd(5'h14, 8'h00);
        for (i = 0; i < 4; i = i + 1) begin
            seed = xs(seed);
            v = seed[7:0] & 8'h9B;
            bus(1'b1, 5'h04, v);
            rd(5'h04, v);
        end
        bus(1'b1, 5'h18, 8'hFF);
        rd(5'h18, 8'h00);
        rd(5'h05, 8'h00);
        seed = xs(seed);
        far_tx = seed[15:8];
        bus(1'b1, 5'h04, 8'h10);
        bus(1'b1, 5'h00, 8'h07);
        bus(1'b1, 5'h0C, far_tx);
        bus(1'b1, 5'h14, 8'h04);
        bus(1'b1, 5'h08, seed[7:0]);
        t = 0;
        while (irq_out !== 1'b1 && t < 400) begin
            @(posedge mclk_in);
            t = t + 1;
        end
        if (t == 400) num_errors = num_errors + 1;
        rd(5'h08, far_tx);
        chk(far_rx, seed[7:0]);
        rd(5'h10, 8'h05);
        bus(1'b1, 5'h10, 8'h04);
        @(negedge mclk_in);
        chk({7'h00, irq_out}, 8'h00);
        bus(1'b1, 5'h04, 8'h90);
        @(negedge mclk_in);
        chk({7'h00, irq_out}, 8'h01);
        rd(5'h14, 8'h05);
        bus(1'b1, 5'h10, 8'h01);
        @(negedge mclk_in);
        chk({7'h00, irq_out}, 8'h00);
        for (i = 0; i < 11; i = i + 1) begin
            bus(1'b1, 5'h00, rows[i][22:15]);
            bus(1'b1, 5'h04, rows[i][14:7]);
            ss_drv <= rows[i][6];
            wait_mode_in <= rows[i][5];
            repeat (4) @(negedge mclk_in);
            chk({6'h00, roles[4:3]}, {6'h00, rows[i][4:3]});
            chk({5'h00, roles[2:0]}, {5'h00, rows[i][2:0]});
        end
        wait_mode_in <= 1'b0;
        bus(1'b1, 5'h00, 8'h03);
        repeat (4) @(negedge mclk_in);
        rd(5'h00, 8'h01);
        rd(5'h10, 8'h02);
        // A deselected slave preloads its shifter; the top bit waits on the undriven data-out pin.
        ss_drv <= 1'b1;
        seed = xs(seed);
        v = {~far_tx[7], seed[6:0]};
        bus(1'b1, 5'h08, v);
        @(negedge mclk_in);
        chk({6'h00, miso_out, miso_oe_out}, {6'h00, v[7], 1'b0});
        if (exp_q.size() != 0) num_errors = num_errors + 1;
        end_of_test;
    end
endmodule
bind spc_pin_ctrl spc_pin_ctrl_checker chk_u (.mclk_in, .rst_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .wait_mode_in, .irq_out, .port_clock_run_out,
    .sck_oe_out, .mosi_oe_out, .miso_oe_out, .ss_n_oe_out);
